// File: rtl/acmp_ctrl.sv
// digital control, synchroniser and event logic around an analog comparator
//
// Overview of operation
// RULE_01 - result bit shows synchronised comparator, 1-2 cycles late
// RULE_02 - mux enable with converter off picks channel pin
// RULE_03 - bandgap select replaces positive pin input
// RULE_04 - power off bit writable any time
// RULE_05 - mode: toggle, reserved, falling, rising
// RULE_06 - hardware sets flag on matching output event
// RULE_07 - flag cleared by vector acknowledge or one
// RULE_08 - request needs flag, enable and global enable
// RULE_09 - software disables interrupt before changing power
// RULE_10 - software disables interrupt before changing mode
// RULE_11 - capture enable routes result to timer capture
// RULE_12 - pin disable gates digital input to zero
// RULE_13 - software clears converter power reduction before muxing
// RULE_14 - unused pin disable bits read zero
// RULE_15 - edges from synchronised history, none while off
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "acmp_defs.svh"

module acmp_ctrl
    import acmp_pkg::*;
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic NRST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // analog comparator core
    input wire logic CMP_RAW,
    output logic CMP_POWER_OFF,
    output logic POS_SEL_BANDGAP,
    output logic NEG_SEL_CHANNEL,
    output logic [2:0] NEG_CHANNEL,
    // converter side
    input wire logic CONVERTER_ENABLE,
    input wire logic [2:0] CHANNEL_SELECT_FIELD,
    output logic [2:0] CONVERTER_TRIGGER_SELECT,
    // timer capture front end
    output logic CAPTURE_INPUT,
    output logic CAPTURE_ROUTE_EN,
    // comparator pin digital inputs
    input wire logic [1:0] PIN_RAW_IN,
    output logic [1:0] PIN_DIGITAL_IN,
    // interrupt
    input wire logic GLOBAL_IRQ_EN,
    input wire logic IRQ_ACK,
    output logic IRQ
);

    // control registers
    logic negative_mux_enable_r, negative_mux_enable_nxt; // converter mux feeds negative input
    logic [2:0] converter_trigger_select_r, converter_trigger_select_nxt; // stored for the converter
    logic comparator_power_off_r, comparator_power_off_nxt; // analog core power down
    logic bandgap_select_r, bandgap_select_nxt; // bandgap on positive input
    logic compare_irq_enable_r, compare_irq_enable_nxt; // doubles as interrupt mask
    logic capture_route_enable_r, capture_route_enable_nxt; // route to timer capture
    logic [1:0] compare_irq_mode_r, compare_irq_mode_nxt; // trigger selection
    logic [1:0] pin_digital_input_off_r, pin_digital_input_off_nxt; // per pin buffer off
    logic compare_event_flag_r, compare_event_flag_nxt; // sticky event flag

    // synchroniser and edge history
    logic sync_meta_r, sync_meta_nxt; // first stage, read only by second stage
    logic compare_result_r, compare_result_nxt; // second stage, the visible result
    logic result_prev_r, result_prev_nxt; // result one clock earlier

    // read data register
    logic [31:0] prdata_r, prdata_nxt;

    // bus decode and event helpers
    logic setup_phase; // first cycle of a transfer
    logic wr_take; // write committed at this edge
    logic addr_hit; // address maps to a register
    logic rise_edge, fall_edge; // qualified result edges
    logic mode_event; // edge matching the selected mode
    logic w1c_flag; // software clearing the flag
    acmp_mode_e mode; // typed view of the mode field

    // address decode, shared by writes and error answer
    always_comb begin
        unique case (PADDR)
            `ACMP_OFS_CONV_CTRL, `ACMP_OFS_CMP_CTRL, `ACMP_OFS_PIN_OFF,
            `ACMP_OFS_IRQ_STATUS, `ACMP_OFS_IRQ_MASK: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end

    // zero wait state slave; read data captured in setup so it comes from a flop
    assign setup_phase = PSEL && !PENABLE;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !addr_hit;
    assign wr_take = PSEL && PENABLE && PWRITE && addr_hit;
    assign PRDATA = prdata_r;

    // read mux; unused bits and reserved fields read zero
    always_comb begin
        prdata_nxt = prdata_r;
        if (setup_phase) begin
            prdata_nxt = 32'h0000_0000;
            unique case (PADDR)
                `ACMP_OFS_CONV_CTRL: begin
                    prdata_nxt[`ACMP_CONV_MUX_EN_BIT] = negative_mux_enable_r;
                    prdata_nxt[`ACMP_CONV_TRIG_LSB +: `ACMP_CONV_TRIG_W] = converter_trigger_select_r;
                end
                `ACMP_OFS_CMP_CTRL: begin
                    prdata_nxt[`ACMP_CMP_POWER_OFF_BIT] = comparator_power_off_r;
                    prdata_nxt[`ACMP_CMP_BANDGAP_BIT] = bandgap_select_r;
                    prdata_nxt[`ACMP_CMP_RESULT_BIT] = compare_result_r; // see RULE_01
                    prdata_nxt[`ACMP_CMP_FLAG_BIT] = compare_event_flag_r;
                    prdata_nxt[`ACMP_CMP_IRQ_EN_BIT] = compare_irq_enable_r;
                    prdata_nxt[`ACMP_CMP_CAPTURE_BIT] = capture_route_enable_r;
                    prdata_nxt[`ACMP_CMP_MODE_LSB +: 2] = compare_irq_mode_r;
                end
                `ACMP_OFS_PIN_OFF: begin
                    // upper bits stay zero whatever was written; see RULE_14
                    prdata_nxt[`ACMP_PIN_OFF_W-1:0] = pin_digital_input_off_r;
                end
                `ACMP_OFS_IRQ_STATUS: prdata_nxt[`ACMP_IRQ_EVENT_BIT] = compare_event_flag_r;
                `ACMP_OFS_IRQ_MASK: prdata_nxt[`ACMP_IRQ_EVENT_BIT] = compare_irq_enable_r;
                default: prdata_nxt = 32'h0000_0000; // unmapped reads return zero
            endcase
        end
    end

    // register writes; the power off bit has no lock and is writable any time
    always_comb begin
        negative_mux_enable_nxt = negative_mux_enable_r;
        converter_trigger_select_nxt = converter_trigger_select_r;
        comparator_power_off_nxt = comparator_power_off_r;
        bandgap_select_nxt = bandgap_select_r;
        compare_irq_enable_nxt = compare_irq_enable_r;
        capture_route_enable_nxt = capture_route_enable_r;
        compare_irq_mode_nxt = compare_irq_mode_r;
        pin_digital_input_off_nxt = pin_digital_input_off_r;
        if (wr_take) begin
            unique case (PADDR)
                `ACMP_OFS_CONV_CTRL: begin
                    negative_mux_enable_nxt = PWDATA[`ACMP_CONV_MUX_EN_BIT];
                    converter_trigger_select_nxt = PWDATA[`ACMP_CONV_TRIG_LSB +: `ACMP_CONV_TRIG_W];
                end
                `ACMP_OFS_CMP_CTRL: begin
                    comparator_power_off_nxt = PWDATA[`ACMP_CMP_POWER_OFF_BIT]; // see RULE_04
                    bandgap_select_nxt = PWDATA[`ACMP_CMP_BANDGAP_BIT];
                    compare_irq_enable_nxt = PWDATA[`ACMP_CMP_IRQ_EN_BIT];
                    capture_route_enable_nxt = PWDATA[`ACMP_CMP_CAPTURE_BIT];
                    // a mode change with the enable set may fire; software guards it
                    compare_irq_mode_nxt = PWDATA[`ACMP_CMP_MODE_LSB +: 2];
                end
                `ACMP_OFS_PIN_OFF: begin
                    pin_digital_input_off_nxt = PWDATA[`ACMP_PIN_OFF_W-1:0]; // see RULE_14
                end
                `ACMP_OFS_IRQ_MASK: compare_irq_enable_nxt = PWDATA[`ACMP_IRQ_EVENT_BIT];
                default: begin
                    // status and unmapped writes touch no control bit
                end
            endcase
        end
    end

    // two flop synchroniser; result appears one to two clocks after the core
    always_comb begin
        sync_meta_nxt = CMP_RAW; // see RULE_01
        compare_result_nxt = sync_meta_r;
        result_prev_nxt = compare_result_r;
    end

    // edge detect on synchronised history, muted while the core is powered off
    assign rise_edge = !comparator_power_off_r && compare_result_r && !result_prev_r; // see RULE_15
    assign fall_edge = !comparator_power_off_r && !compare_result_r && result_prev_r; // see RULE_15
    assign mode = acmp_mode_e'(compare_irq_mode_r);

    // trigger selection; the reserved code never fires
    always_comb begin
        unique case (mode)
            ACMP_MODE_TOGGLE: mode_event = rise_edge || fall_edge; // see RULE_05
            ACMP_MODE_RESERVED: mode_event = 1'b0;
            ACMP_MODE_FALL: mode_event = fall_edge;
            ACMP_MODE_RISE: mode_event = rise_edge;
        endcase
    end

    // write one to clear through either the control or the status register
    assign w1c_flag = wr_take && (((PADDR == `ACMP_OFS_CMP_CTRL) && PWDATA[`ACMP_CMP_FLAG_BIT])
        || ((PADDR == `ACMP_OFS_IRQ_STATUS) && PWDATA[`ACMP_IRQ_EVENT_BIT]));

    // sticky flag; a new event in the clearing cycle wins so none is lost
    always_comb begin
        compare_event_flag_nxt = compare_event_flag_r;
        if (IRQ_ACK || w1c_flag) begin
            compare_event_flag_nxt = 1'b0; // see RULE_07
        end
        if (mode_event) begin
            compare_event_flag_nxt = 1'b1; // see RULE_06
        end
    end

    // all state registers; synchronous active low reset
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            negative_mux_enable_r <= 1'(`ACMP_CONV_RESET >> `ACMP_CONV_MUX_EN_BIT);
            converter_trigger_select_r <= 3'h0;
            comparator_power_off_r <= 1'b0;
            bandgap_select_r <= 1'b0;
            compare_irq_enable_r <= 1'b0;
            capture_route_enable_r <= 1'b0;
            compare_irq_mode_r <= 2'h0;
            pin_digital_input_off_r <= `ACMP_PIN_OFF_RESET;
            compare_event_flag_r <= 1'b0;
            sync_meta_r <= 1'b0;
            compare_result_r <= 1'b0;
            result_prev_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            negative_mux_enable_r <= negative_mux_enable_nxt;
            converter_trigger_select_r <= converter_trigger_select_nxt;
            comparator_power_off_r <= comparator_power_off_nxt;
            bandgap_select_r <= bandgap_select_nxt;
            compare_irq_enable_r <= compare_irq_enable_nxt;
            capture_route_enable_r <= capture_route_enable_nxt;
            compare_irq_mode_r <= compare_irq_mode_nxt;
            pin_digital_input_off_r <= pin_digital_input_off_nxt;
            compare_event_flag_r <= compare_event_flag_nxt;
            sync_meta_r <= sync_meta_nxt;
            compare_result_r <= compare_result_nxt;
            result_prev_r <= result_prev_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    // analog selections; converter mux only usable while the converter is off
    assign NEG_SEL_CHANNEL = negative_mux_enable_r && !CONVERTER_ENABLE; // see RULE_02
    assign NEG_CHANNEL = CHANNEL_SELECT_FIELD; // see RULE_02
    assign POS_SEL_BANDGAP = bandgap_select_r; // see RULE_03
    assign CMP_POWER_OFF = comparator_power_off_r; // see RULE_04
    assign CONVERTER_TRIGGER_SELECT = converter_trigger_select_r;

    // capture route: held low when not routed so the timer sees no edge
    assign CAPTURE_INPUT = capture_route_enable_r && compare_result_r; // see RULE_11
    assign CAPTURE_ROUTE_EN = capture_route_enable_r; // see RULE_11

    // digital input gating per comparator pin
    genvar gi;
    generate
        for (gi = 0; gi < `ACMP_PIN_OFF_W; gi++) begin : g_pin
            assign PIN_DIGITAL_IN[gi] = PIN_RAW_IN[gi] && !pin_digital_input_off_r[gi]; // see RULE_12
        end
    endgenerate

    // level request; the enable acts as the mask of the single status bit
    assign IRQ = compare_event_flag_r && compare_irq_enable_r && GLOBAL_IRQ_EN; // see RULE_08

    // checks kept beside the logic
    a_result_sync_delay: assert property (@(posedge CLOCK) disable iff (!NRST) // see RULE_01
        ($past(NRST) && $past(NRST, 2)) |-> (compare_result_r == $past(CMP_RAW, 2)))
        else $error("result bit not two clocks behind comparator");

    a_neg_mux_select: assert property (@(posedge CLOCK) disable iff (!NRST) // see RULE_02
        NEG_SEL_CHANNEL == (negative_mux_enable_r && !CONVERTER_ENABLE))
        else $error("negative input selection wrong");

    a_power_off_write: assert property (@(posedge CLOCK) disable iff (!NRST) // see RULE_04
        (wr_take && PADDR == `ACMP_OFS_CMP_CTRL) |=> (CMP_POWER_OFF == $past(PWDATA[7])))
        else $error("power off bit did not take write");

    a_rise_mode_event: assert property (@(posedge CLOCK) disable iff (!NRST) // see RULE_05
        (compare_irq_mode_r == 2'b11 && !comparator_power_off_r && !result_prev_r && compare_result_r)
        |=> compare_event_flag_r)
        else $error("rising edge did not set flag");

    a_reserved_quiet: assert property (@(posedge CLOCK) disable iff (!NRST) // see RULE_05
        (compare_irq_mode_r == 2'b01) |=> !$rose(compare_event_flag_r))
        else $error("reserved mode set the flag");

    a_flag_needs_cause: assert property (@(posedge CLOCK) disable iff (!NRST) // see RULE_06
        $rose(compare_event_flag_r) |-> $past(compare_result_r) != $past(result_prev_r))
        else $error("flag set without an output edge");

    a_ack_clears_flag: assert property (@(posedge CLOCK) disable iff (!NRST) // see RULE_07
        (IRQ_ACK && !mode_event) |=> !compare_event_flag_r)
        else $error("acknowledge did not clear flag");

    a_irq_gating: assert property (@(posedge CLOCK) disable iff (!NRST) // see RULE_08
        IRQ |-> (compare_event_flag_r && compare_irq_enable_r && GLOBAL_IRQ_EN))
        else $error("interrupt raised without all enables");

    // a zero written to the mask must silence the request on the next cycle
    a_mask_blocks_irq: assert property (@(posedge CLOCK) disable iff (!NRST) // see RULE_08
        (wr_take && PADDR == `ACMP_OFS_IRQ_MASK && !PWDATA[`ACMP_IRQ_EVENT_BIT]) |=> !IRQ)
        else $error("interrupt request not blocked by zero enable");

    a_capture_route: assert property (@(posedge CLOCK) disable iff (!NRST) // see RULE_11
        !capture_route_enable_r |-> !CAPTURE_INPUT)
        else $error("capture input driven while not routed");

    a_pin_gate_zero: assert property (@(posedge CLOCK) disable iff (!NRST) // see RULE_12
        pin_digital_input_off_r[0] |-> !PIN_DIGITAL_IN[0])
        else $error("disabled pin input not zero");

    a_pin_upper_zero: assert property (@(posedge CLOCK) disable iff (!NRST) // see RULE_14
        ($past(setup_phase) && $past(PADDR) == `ACMP_OFS_PIN_OFF) |-> (PRDATA[31:2] == 30'h0))
        else $error("unused pin disable bits not zero");

    a_off_no_edge: assert property (@(posedge CLOCK) disable iff (!NRST) // see RULE_15
        comparator_power_off_r |-> !mode_event)
        else $error("edge detected while powered off");

endmodule // acmp_ctrl
`default_nettype wire

// File: rtl/acmp_defs.svh
// register offsets, field positions and reset values of the comparator control block
`ifndef ACMP_DEFS_SVH
`define ACMP_DEFS_SVH

// byte offsets of the registers on the apb bus
`define ACMP_OFS_CONV_CTRL 12'h000
`define ACMP_OFS_CMP_CTRL 12'h004
`define ACMP_OFS_PIN_OFF 12'h008
`define ACMP_OFS_IRQ_STATUS 12'h00c
`define ACMP_OFS_IRQ_MASK 12'h010

// converter control/status b fields
`define ACMP_CONV_MUX_EN_BIT 6
`define ACMP_CONV_TRIG_LSB 0
`define ACMP_CONV_TRIG_W 3
`define ACMP_CONV_RESET 8'h00

// comparator control/status fields
`define ACMP_CMP_POWER_OFF_BIT 7
`define ACMP_CMP_BANDGAP_BIT 6
`define ACMP_CMP_RESULT_BIT 5
`define ACMP_CMP_FLAG_BIT 4
`define ACMP_CMP_IRQ_EN_BIT 3
`define ACMP_CMP_CAPTURE_BIT 2
`define ACMP_CMP_MODE_LSB 0
`define ACMP_CMP_RESET 8'h00

// pin digital input disable fields
`define ACMP_PIN_OFF_W 2
`define ACMP_PIN_OFF_RESET 2'h0

// interrupt status and mask layout
`define ACMP_IRQ_EVENT_BIT 0

`endif

// File: rtl/acmp_pkg.sv
// types shared by the comparator control block
package acmp_pkg;

    // interrupt trigger selection of the comparator output
    typedef enum logic [1:0] {
        ACMP_MODE_TOGGLE = 2'b00,
        ACMP_MODE_RESERVED = 2'b01,
        ACMP_MODE_FALL = 2'b10,
        ACMP_MODE_RISE = 2'b11
    } acmp_mode_e;

endpackage

// File: testbench/acmp_ctrl_tb.sv
// self-checking testbench of the comparator control block
`timescale 1ns/1ns
`default_nettype none
`include "acmp_defs.svh"

module testbench
    import acmp_pkg::*;
();
    // one table row: register write, expected read-back and error flag
    typedef struct {
        logic [11:0] a;
        logic [31:0] w;
        logic [31:0] e;
        logic err;
    } acmp_row_s;
    logic clock, nrst, psel, penable, pwrite, pready, pslverr; // clock, reset and apb
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic cmp_raw, cmp_power_off, pos_sel_bandgap, neg_sel_channel; // analog core side
    logic [2:0] neg_channel, channel_select_field, converter_trigger_select;
    logic converter_enable, capture_input, capture_route_en;
    logic [1:0] pin_raw_in, pin_digital_in; // pin buffers
    logic global_irq_en, irq_ack, irq; // interrupt
    int error_cnt = 0;
    int cmp_count = 0;
    logic [31:0] v;
    logic e;
    // ordinary register cases, each row written then read back
    acmp_row_s rows [11] = '{
        '{`ACMP_OFS_CONV_CTRL, 32'hffffffff, 32'h00000047, 1'b0},
        '{`ACMP_OFS_CONV_CTRL, 32'h00000005, 32'h00000005, 1'b0},
        '{`ACMP_OFS_CMP_CTRL, 32'hffffffff, 32'h000000cf, 1'b0},
        '{`ACMP_OFS_IRQ_MASK, 32'h00000000, 32'h00000000, 1'b0},
        '{`ACMP_OFS_CMP_CTRL, 32'h00000000, 32'h00000000, 1'b0},
        '{`ACMP_OFS_IRQ_MASK, 32'hffffffff, 32'h00000001, 1'b0},
        '{`ACMP_OFS_IRQ_MASK, 32'h00000000, 32'h00000000, 1'b0},
        '{`ACMP_OFS_PIN_OFF, 32'hffffffff, 32'h00000003, 1'b0},
        '{`ACMP_OFS_PIN_OFF, 32'h00000000, 32'h00000000, 1'b0},
        '{`ACMP_OFS_IRQ_STATUS, 32'h00000000, 32'h00000000, 1'b0},
        '{12'h014, 32'hffffffff, 32'h00000000, 1'b1}
    };

    acmp_ctrl i_dut (.CLOCK(clock), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .CMP_RAW(cmp_raw), .CMP_POWER_OFF(cmp_power_off), .POS_SEL_BANDGAP(pos_sel_bandgap),
        .NEG_SEL_CHANNEL(neg_sel_channel), .NEG_CHANNEL(neg_channel), .CONVERTER_ENABLE(converter_enable),
        .CHANNEL_SELECT_FIELD(channel_select_field), .CONVERTER_TRIGGER_SELECT(converter_trigger_select),
        .CAPTURE_INPUT(capture_input), .CAPTURE_ROUTE_EN(capture_route_en), .PIN_RAW_IN(pin_raw_in),
        .PIN_DIGITAL_IN(pin_digital_in), .GLOBAL_IRQ_EN(global_irq_en), .IRQ_ACK(irq_ack), .IRQ(irq));

    // 100 mhz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // compare and count, report at once
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // verdict and end of run
    task automatic test_done();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // one apb transfer: setup, then access until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            chk(32'h0, 32'h1);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // let the edge's register updates land before callers look at outputs
        #1;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic y;
        apb(1'b1, a, d, x, y);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] x;
        logic y;
        apb(1'b0, a, 32'h0, x, y);
        chk(x, exp);
    endtask

    // wait n edges, then let that edge's updates land
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // reset pulse followed by a read of every register
    task automatic do_reset();
        @(posedge clock);
        nrst <= 1'b0;
        cyc(9);
        chk(irq, 1'b0);
        chk(pready, 1'b1);
        @(posedge clock);
        nrst <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rd(12'(i * 4), 32'h0);
        end
        chk({cmp_power_off, pos_sel_bandgap, capture_route_en, converter_trigger_select}, 6'h00);
    endtask

    // comparator edge: drive the raw output, wait past sync and detection
    task automatic edge_to(input logic lvl);
        @(posedge clock);
        cmp_raw <= lvl;
        cyc(6);
    endtask

    initial begin
        {psel, penable, pwrite, cmp_raw, converter_enable, global_irq_en, irq_ack} = 7'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        channel_select_field = 3'h0;
        pin_raw_in = 2'h3;
        nrst = 1'b0;
        do_reset();
        // table of register cases
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].w, v, e);
            chk(e, rows[i].err);
            apb(1'b0, rows[i].a, 32'h0, v, e);
            chk(v, rows[i].e);
            chk(e, rows[i].err);
        end
        // negative input selection over every channel
        wr(`ACMP_OFS_CONV_CTRL, 32'h00000046);
        chk(converter_trigger_select, 3'h6);
        for (int c = 0; c < 8; c++) begin
            @(posedge clock);
            channel_select_field <= 3'(c);
            converter_enable <= 1'b0;
            cyc(1);
            chk({neg_sel_channel, neg_channel}, {1'b1, 3'(c)});
            @(posedge clock);
            converter_enable <= 1'b1;
            cyc(1);
            chk(neg_sel_channel, 1'b0);
        end
        wr(`ACMP_OFS_CONV_CTRL, 32'h0);
        @(posedge clock);
        converter_enable <= 1'b0;
        cyc(1);
        chk(neg_sel_channel, 1'b0);
        // bandgap selection and pin buffers
        wr(`ACMP_OFS_CMP_CTRL, 32'h00000040);
        chk(pos_sel_bandgap, 1'b1);
        wr(`ACMP_OFS_CMP_CTRL, 32'h0);
        chk(pos_sel_bandgap, 1'b0);
        wr(`ACMP_OFS_PIN_OFF, 32'h1);
        chk(pin_digital_in, 2'b10);
        wr(`ACMP_OFS_PIN_OFF, 32'h2);
        chk(pin_digital_in, 2'b01);
        wr(`ACMP_OFS_PIN_OFF, 32'h0);
        // every interrupt mode on both edges, enable held low while changing it
        for (int m = 0; m < 4; m++) begin
            wr(`ACMP_OFS_CMP_CTRL, 32'(m));
            wr(`ACMP_OFS_IRQ_STATUS, 32'h1);
            edge_to(1'b1);
            v = (m == 0 || m == 3) ? 32'h1 : 32'h0;
            rd(`ACMP_OFS_CMP_CTRL, 32'h20 | 32'(m) | (v << 4));
            rd(`ACMP_OFS_IRQ_STATUS, v);
            wr(`ACMP_OFS_IRQ_STATUS, 32'h1);
            edge_to(1'b0);
            rd(`ACMP_OFS_IRQ_STATUS, (m == 0 || m == 2) ? 32'h1 : 32'h0);
        end
        // capture route and synchroniser delay
        wr(`ACMP_OFS_CMP_CTRL, 32'h00000004);
        chk(capture_route_en, 1'b1);
        @(posedge clock);
        cmp_raw <= 1'b1;
        #1;
        chk(capture_input, 1'b0);
        cyc(2);
        chk(capture_input, 1'b1);
        wr(`ACMP_OFS_CMP_CTRL, 32'h0);
        chk({capture_route_en, capture_input}, 2'b00);
        edge_to(1'b0);
        // flag, enable, global enable, acknowledge and write-one clear
        wr(`ACMP_OFS_CMP_CTRL, 32'h3);
        wr(`ACMP_OFS_IRQ_STATUS, 32'h1);
        @(posedge clock);
        global_irq_en <= 1'b1;
        edge_to(1'b1);
        chk(irq, 1'b0);
        wr(`ACMP_OFS_IRQ_MASK, 32'h1);
        chk(irq, 1'b1);
        @(posedge clock);
        global_irq_en <= 1'b0;
        cyc(1);
        chk(irq, 1'b0);
        @(posedge clock);
        global_irq_en <= 1'b1;
        irq_ack <= 1'b1;
        @(posedge clock);
        irq_ack <= 1'b0;
        cyc(1);
        chk(irq, 1'b0);
        rd(`ACMP_OFS_IRQ_STATUS, 32'h0);
        edge_to(1'b0);
        edge_to(1'b1);
        chk(irq, 1'b1);
        wr(`ACMP_OFS_CMP_CTRL, 32'h1b);
        chk(irq, 1'b0);
        // power off blocks edge detection, enable cleared first
        wr(`ACMP_OFS_IRQ_MASK, 32'h0);
        wr(`ACMP_OFS_CMP_CTRL, 32'h80);
        chk(cmp_power_off, 1'b1);
        wr(`ACMP_OFS_IRQ_STATUS, 32'h1);
        edge_to(1'b0);
        rd(`ACMP_OFS_IRQ_STATUS, 32'h0);
        edge_to(1'b1);
        wr(`ACMP_OFS_CMP_CTRL, 32'h0);
        chk(cmp_power_off, 1'b0);
        // reset in mid-run with registers set
        wr(`ACMP_OFS_CONV_CTRL, 32'h47);
        wr(`ACMP_OFS_CMP_CTRL, 32'h4c);
        @(posedge clock);
        cmp_raw <= 1'b0;
        do_reset();
        test_done();
    end

    // watchdog against a hang
    initial begin
        #100000;
        error_cnt++;
        test_done();
    end
endmodule // testbench
`default_nettype wire
